// ### rtl/integer_float_add_unit_consts.svh
// offsets, field positions, encodings and reset values of the add unit
`ifndef INTEGER_FLOAT_ADD_UNIT_CONSTS_SVH
`define INTEGER_FLOAT_ADD_UNIT_CONSTS_SVH
// register offsets
`define OFS_CTRL 8'h00
`define OFS_FCTL 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c
// control register fields and reset
`define CTRL_FPU_EN 0
`define CTRL_PAIR_EN 1
`define CTRL_RESET 2'h0
// float_ctl_status layout and reset
`define FCTL_RM_MSB 1
`define FCTL_RM_LSB 0
`define FCTL_FLAG_MSB 6
`define FCTL_FLAG_LSB 2
`define FCTL_EN_MSB 11
`define FCTL_EN_LSB 7
`define FCTL_CAUSE_MSB 17
`define FCTL_CAUSE_LSB 12
`define FCTL_RESET 18'h00000
// interrupt status bits and reset
`define IRQ_INT_OVF 0
`define IRQ_FP_TRAP 1
`define IRQ_UNUSABLE 2
`define IRQ_RESET 3'h0
// instruction fields
`define OPC_MSB 31
`define OPC_LSB 26
`define FMT_MSB 25
`define FMT_LSB 21
`define SRCB_MSB 20
`define SRCB_LSB 16
`define DST_MSB 15
`define DST_LSB 11
`define SHAMT_MSB 10
`define SHAMT_LSB 6
`define FN_MSB 5
`define FN_LSB 0
// encodings
`define OP_SPECIAL 6'h00
`define OP_IMM_TRAP 6'h08
`define OP_IMM_WRAP 6'h09
`define OP_FLOAT 6'h11
`define FN_ADD_TRAP 6'h20
`define FN_ADD_WRAP 6'h21
`define FN_FABS 6'h05
`define FN_FADD 6'h00
`define FMT_SINGLE 5'h10
`define FMT_DOUBLE 5'h11
`define FMT_PAIRED 5'h16
// float formats
`define SGL_EW 8
`define SGL_MW 23
`define DBL_EW 11
`define DBL_MW 52
`endif

// ### rtl/integer_float_add_unit_pkg.sv
// types shared by the add unit and its float adder core
package integer_float_add_unit_pkg;
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [63:0] opnd_a;
      logic [63:0] opnd_b;
   } issue_t;
   typedef struct packed {
      logic valid;
      logic int_wr;
      logic fp_wr;
      logic [4:0] dest;
      logic [63:0] data;
   } retire_t;
   typedef struct packed {
      logic int_ovf;
      logic fp_trap;
      logic unusable;
      logic reserved;
   } excp_t;
   typedef struct packed {
      logic unimpl;
      logic invalid;
      logic divzero;
      logic overflow;
      logic underflow;
      logic inexact;
   } fp_cause_t;
   typedef enum logic [1:0] {
      RND_NEAR = 2'h0,
      RND_ZERO = 2'h1,
      RND_UP = 2'h2,
      RND_DOWN = 2'h3
   } round_mode_t;
   typedef enum logic [6:0] {
      OP_NONE = 7'h01,
      OP_ADD_TRAP = 7'h02,
      OP_ADD_WRAP = 7'h04,
      OP_IMM_TRAP = 7'h08,
      OP_IMM_WRAP = 7'h10,
      OP_FABS = 7'h20,
      OP_FADD = 7'h40
   } op_t;
endpackage : integer_float_add_unit_pkg

// ### rtl/fp_add_core.sv
// combinational float adder for one format with rounding and flags
`timescale 1ns/1ps
module fp_add_core
   import integer_float_add_unit_pkg::*;
#(
   parameter int EW = 8,
   parameter int MW = 23
)
(
   input wire logic [EW+MW:0] a_i,
   input wire logic [EW+MW:0] b_i,
   input wire round_mode_t rmode_i,
   output logic [EW+MW:0] sum_o,
   output fp_cause_t cause_o
);
   localparam int XW = MW + 5;
   logic [EW+MW:0] big, sml;
   logic [EW-1:0] dexp;
   logic [MW+3:0] mb, ms, mshift;
   logic [XW-1:0] acc;
   logic [MW+1:0] rnd;
   logic signed [EW+1:0] ex;
   logic sgn, inc, nan_a, nan_b, inf_a, inf_b, den;
   always_comb
   begin
      sum_o = '0;
      cause_o = '0;
      big = (a_i[EW+MW-1:0] >= b_i[EW+MW-1:0]) ? a_i : b_i;
      sml = (a_i[EW+MW-1:0] >= b_i[EW+MW-1:0]) ? b_i : a_i;
      nan_a = (&a_i[EW+MW-1:MW]) && (|a_i[MW-1:0]);
      nan_b = (&b_i[EW+MW-1:MW]) && (|b_i[MW-1:0]);
      inf_a = (&a_i[EW+MW-1:MW]) && !(|a_i[MW-1:0]);
      inf_b = (&b_i[EW+MW-1:MW]) && !(|b_i[MW-1:0]);
      den = (a_i[EW+MW-1:MW] == '0 && |a_i[MW-1:0]) || (b_i[EW+MW-1:MW] == '0 && |b_i[MW-1:0]);
      sgn = big[EW+MW];
      dexp = big[EW+MW-1:MW] - sml[EW+MW-1:MW];
      mb = {|big[EW+MW-1:MW], big[MW-1:0], 3'h0};
      ms = {|sml[EW+MW-1:MW], sml[MW-1:0], 3'h0};
      mshift = (dexp > EW'(MW + 3)) ? '0 : (ms >> dexp);
      mshift[0] = mshift[0] | ((dexp > EW'(MW + 3)) ? |ms : |(ms & ~({(MW+4){1'b1}} << dexp)));
      acc = (a_i[EW+MW] == b_i[EW+MW]) ? ({1'b0, mb} + {1'b0, mshift})
                                         : ({1'b0, mb} - {1'b0, mshift});
      ex = $signed({2'h0, big[EW+MW-1:MW]});
      inc = 1'b0;
      rnd = '0;
      // quiet default result for invalid operations
      if (nan_a || nan_b || (inf_a && inf_b && a_i[EW+MW] != b_i[EW+MW]))
      begin
         cause_o.invalid = 1'b1;
         sum_o = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
      end
      else if (inf_a || inf_b)
         sum_o = big;
      // denormal operands and tiny results are left to software
      else if (den)
         cause_o.unimpl = 1'b1;
      else if (acc == '0)
         sum_o = {(a_i[EW+MW] == b_i[EW+MW]) ? sgn : (rmode_i == RND_DOWN), {(EW+MW){1'b0}}};
      else
      begin
         if (acc[XW-1])
         begin
            acc = {1'b0, acc[XW-1:2], acc[1] | acc[0]};
            // a one-bit signed literal would be minus one here
            ex = ex + 2'sb01;
         end
         for (int i = 0; i < XW - 1; i++)
         begin
            if (!acc[XW-2])
            begin
               acc = acc << 1;
               ex = ex - 2'sb01;
            end
         end
         cause_o.inexact = acc[2] | (|acc[1:0]);
         unique case (rmode_i)
            RND_NEAR: inc = acc[2] & ((|acc[1:0]) | acc[3]);
            RND_ZERO: inc = 1'b0;
            RND_UP: inc = !sgn & cause_o.inexact;
            RND_DOWN: inc = sgn & cause_o.inexact;
         endcase
         rnd = {1'b0, acc[XW-2:3]} + {{(MW+1){1'b0}}, inc};
         if (rnd[MW+1])
            ex = ex + 2'sb01;
         if (ex <= 0)
         begin
            cause_o = '0;
            cause_o.unimpl = 1'b1;
         end
         else if (ex >= $signed({2'h0, {EW{1'b1}}}))
         begin
            cause_o.overflow = 1'b1;
            cause_o.inexact = 1'b1;
            if (rmode_i == RND_NEAR || (rmode_i == RND_UP && !sgn) || (rmode_i == RND_DOWN && sgn))
               sum_o = {sgn, {EW{1'b1}}, {MW{1'b0}}};
            else
               sum_o = {sgn, {(EW-1){1'b1}}, 1'b0, {MW{1'b1}}};
         end
         else
            sum_o = {sgn, ex[EW-1:0], rnd[MW-1:0]};
      end
   end
endmodule : fp_add_core

// ### rtl/integer_float_add_unit.sv
// integer and floating add execution unit with register port and interrupt
`timescale 1ns/1ps
// Operation
// [RULE_01] trapping register add forms 33-bit sign-extended sum; overflow when bits 32, 31 differ
// [RULE_02] trapping register add overflow: destination untouched, integer overflow exception raised
// [RULE_03] trapping register add without overflow writes sign-extended low 32 sum bits
// [RULE_04] trapping register add decoded by opcode 000000, function 100000, zero bits 10..6
// [RULE_05] trapping immediate add sign-extends immediate; overflow keeps target, raises exception
// [RULE_06] trapping immediate add without overflow writes sign-extended 32-bit sum
// [RULE_07] wrapping immediate add is modulo 2^32, sign-extended, never traps
// [RULE_08] wrapping register add, function 100001, modulo 2^32, sign-extended, never traps
// [RULE_09] software supplies integer sources already sign-extended from bit 31
// [RULE_10] float absolute value clears sign in selected format; NaN signals invalid
// [RULE_11] paired absolute value handles both halves apart and ORs their exceptions
// [RULE_12] without a taken exception, new cause bits are ORed into sticky flags
// [RULE_13] float add rounds exact sum by the current rounding mode
// [RULE_14] paired add sums upper and lower halves apart and ORs their exceptions
// [RULE_15] add flags unimplemented, invalid, inexact, overflow, underflow; absolute only first two; here add never flags underflow, absolute only invalid
// [RULE_16] disabled float unit or unimplemented form raises unusable or reserved exception
// [RULE_17] software avoids paired forms while only 16 float registers are in use
// [RULE_18] software names valid float registers holding operands of the chosen format
// [RULE_19] format field bits 25..21 selects single, double or paired-single operation
`include "integer_float_add_unit_consts.svh"
module integer_float_add_unit
   import integer_float_add_unit_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire issue_t issue_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output retire_t retire_o,
   output excp_t excp_o,
   output logic irq_o
);
   // ***************************************************************
   // decode
   // ***************************************************************
   op_t op;
   logic [5:0] opcode, funct;
   logic [4:0] fmt, shamt, srcb_f, dst_f;
   logic [1:0] ctrl_ff;
   logic [17:0] fctl_ff, nxt_fctl;
   logic fmt_single, fmt_double, fmt_paired, form_ok, fp_op, fp_go;
   logic fp_unusable, fp_reserved, fp_trap;

   assign opcode = issue_i.instr[`OPC_MSB:`OPC_LSB];
   assign funct = issue_i.instr[`FN_MSB:`FN_LSB];
   assign fmt = issue_i.instr[`FMT_MSB:`FMT_LSB];
   assign shamt = issue_i.instr[`SHAMT_MSB:`SHAMT_LSB];
   assign srcb_f = issue_i.instr[`SRCB_MSB:`SRCB_LSB];
   assign dst_f = issue_i.instr[`DST_MSB:`DST_LSB];

   always_comb
   begin
      op = OP_NONE;
      if (issue_i.valid)
      begin
         case (opcode)
            `OP_SPECIAL:
            begin
               // [RULE_04] register add decode
               if (shamt == 5'h00 && funct == `FN_ADD_TRAP)
                  op = OP_ADD_TRAP;
               // [RULE_08] wrapping add decode
               else if (shamt == 5'h00 && funct == `FN_ADD_WRAP)
                  op = OP_ADD_WRAP;
            end
            `OP_IMM_TRAP: op = OP_IMM_TRAP;
            `OP_IMM_WRAP: op = OP_IMM_WRAP;
            `OP_FLOAT:
            begin
               // [RULE_10] absolute value decode
               if (funct == `FN_FABS && srcb_f == 5'h00)
                  op = OP_FABS;
               // [RULE_13] float add decode
               else if (funct == `FN_FADD)
                  op = OP_FADD;
            end
            default: op = OP_NONE;
         endcase
      end
   end

   // [RULE_19] format selection
   assign fmt_single = (fmt == `FMT_SINGLE);
   assign fmt_double = (fmt == `FMT_DOUBLE);
   assign fmt_paired = (fmt == `FMT_PAIRED);
   assign form_ok = fmt_single | fmt_double | (fmt_paired & ctrl_ff[`CTRL_PAIR_EN]);
   assign fp_op = (op == OP_FABS) || (op == OP_FADD);
   // [RULE_16] unusable and reserved forms
   assign fp_unusable = fp_op & ~ctrl_ff[`CTRL_FPU_EN];
   assign fp_reserved = fp_op & ctrl_ff[`CTRL_FPU_EN] & ~form_ok;
   assign fp_go = fp_op & ctrl_ff[`CTRL_FPU_EN] & form_ok;

   // ***************************************************************
   // integer adder
   // ***************************************************************
   logic [31:0] src_a, src_b;
   logic [32:0] sum33;
   logic imm_op, int_op, int_ovf;

   assign imm_op = (op == OP_IMM_TRAP) || (op == OP_IMM_WRAP);
   assign int_op = imm_op || (op == OP_ADD_TRAP) || (op == OP_ADD_WRAP);
   assign src_a = issue_i.opnd_a[31:0];
   // [RULE_05] sign-extended immediate
   assign src_b = imm_op ? {{16{issue_i.instr[15]}}, issue_i.instr[15:0]} : issue_i.opnd_b[31:0];
   // [RULE_01] 33-bit sum from bit 31 extension
   assign sum33 = {src_a[31], src_a} + {src_b[31], src_b};
   // [RULE_07] only the trapping forms see overflow
   assign int_ovf = ((op == OP_ADD_TRAP) || (op == OP_IMM_TRAP)) && (sum33[32] != sum33[31]);

   // ***************************************************************
   // float datapath
   // ***************************************************************
   logic [31:0] lane_sum [2];
   logic [31:0] lane_abs [2];
   logic lane_nan [2];
   fp_cause_t lane_cause [2];
   fp_cause_t dbl_cause, fp_cause;
   logic [63:0] dbl_sum, fp_res;
   logic dbl_nan;
   round_mode_t rmode;

   assign rmode = round_mode_t'(fctl_ff[`FCTL_RM_MSB:`FCTL_RM_LSB]);

   // [RULE_14] independent single lanes
   for (genvar l = 0; l < 2; l++)
   begin : g_lane
      fp_add_core #(.EW(`SGL_EW), .MW(`SGL_MW)) u_core (
         .a_i(issue_i.opnd_a[32*l+31:32*l]),
         .b_i(issue_i.opnd_b[32*l+31:32*l]),
         .rmode_i(rmode),
         .sum_o(lane_sum[l]),
         .cause_o(lane_cause[l])
      );
      assign lane_abs[l] = {1'b0, issue_i.opnd_a[32*l+30:32*l]};
      assign lane_nan[l] = (&issue_i.opnd_a[32*l+30:32*l+23]) && (|issue_i.opnd_a[32*l+22:32*l]);
   end

   // [RULE_13] rounded double add
   fp_add_core #(.EW(`DBL_EW), .MW(`DBL_MW)) u_dbl (
      .a_i(issue_i.opnd_a),
      .b_i(issue_i.opnd_b),
      .rmode_i(rmode),
      .sum_o(dbl_sum),
      .cause_o(dbl_cause)
   );
   assign dbl_nan = (&issue_i.opnd_a[62:52]) && (|issue_i.opnd_a[51:0]);

   always_comb
   begin
      fp_res = '0;
      fp_cause = '0;
      if (op == OP_FABS)
      begin
         // [RULE_10] magnitude, NaN is invalid
         if (fmt_double)
         begin
            fp_res = {1'b0, issue_i.opnd_a[62:0]};
            fp_cause.invalid = dbl_nan;
         end
         // [RULE_11] paired halves, exceptions ORed
         else if (fmt_paired)
         begin
            fp_res = {lane_abs[1], lane_abs[0]};
            fp_cause.invalid = lane_nan[1] | lane_nan[0];
         end
         else
         begin
            fp_res = {32'h0000_0000, lane_abs[0]};
            fp_cause.invalid = lane_nan[0];
         end
      end
      else if (op == OP_FADD)
      begin
         // [RULE_15] add causes pass through
         if (fmt_double)
         begin
            fp_res = dbl_sum;
            fp_cause = dbl_cause;
         end
         // [RULE_14] paired sum, exceptions ORed
         else if (fmt_paired)
         begin
            fp_res = {lane_sum[1], lane_sum[0]};
            fp_cause = lane_cause[1] | lane_cause[0];
         end
         else
         begin
            fp_res = {32'h0000_0000, lane_sum[0]};
            fp_cause = lane_cause[0];
         end
      end
   end

   // unimplemented always traps, others only when enabled
   assign fp_trap = fp_go & (fp_cause.unimpl
                  | (|(fp_cause[4:0] & fctl_ff[`FCTL_EN_MSB:`FCTL_EN_LSB])));

   // ***************************************************************
   // retire and exception outputs
   // ***************************************************************
   retire_t retire_ff;
   excp_t excp_ff;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         retire_ff <= '0;
         excp_ff <= '0;
      end
      else
      begin
         retire_ff <= '0;
         excp_ff.int_ovf <= int_ovf;
         excp_ff.fp_trap <= fp_trap;
         excp_ff.unusable <= fp_unusable;
         excp_ff.reserved <= fp_reserved;
         retire_ff.valid <= (op != OP_NONE);
         if (int_op)
         begin
            // [RULE_02] overflow suppresses the write
            retire_ff.int_wr <= !int_ovf;
            retire_ff.dest <= imm_op ? srcb_f : dst_f;
            // [RULE_03] [RULE_06] sign-extended word result
            retire_ff.data <= {{32{sum33[31]}}, sum33[31:0]};
         end
         else if (fp_go)
         begin
            retire_ff.fp_wr <= !fp_trap;
            retire_ff.dest <= shamt;
            retire_ff.data <= fp_res;
         end
      end
   end
   assign retire_o = retire_ff;
   assign excp_o = excp_ff;

   // ***************************************************************
   // registers and interrupt
   // ***************************************************************
   logic [2:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat, nxt_irq_mask;
   logic [31:0] rdata_ff;
   logic irq_ff;

   always_comb
   begin
      nxt_fctl = fctl_ff;
      if (reg_wr_i && reg_addr_i == `OFS_FCTL)
         nxt_fctl = reg_wdata_i[17:0];
      if (fp_go)
      begin
         nxt_fctl[`FCTL_CAUSE_MSB:`FCTL_CAUSE_LSB] = fp_cause;
         // [RULE_12] sticky flags when no trap
         if (!fp_trap)
            nxt_fctl[`FCTL_FLAG_MSB:`FCTL_FLAG_LSB] = nxt_fctl[`FCTL_FLAG_MSB:`FCTL_FLAG_LSB]
                                                       | fp_cause[4:0];
      end
   end

   always_comb
   begin
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      if (reg_rd_i && reg_addr_i == `OFS_IRQ_STAT)
         nxt_irq_stat = 3'h0;
      if (reg_wr_i && reg_addr_i == `OFS_IRQ_MASK)
         nxt_irq_mask = reg_wdata_i[2:0];
      // events set after the clear so a same-cycle event survives
      nxt_irq_stat[`IRQ_INT_OVF] = nxt_irq_stat[`IRQ_INT_OVF] | int_ovf;
      nxt_irq_stat[`IRQ_FP_TRAP] = nxt_irq_stat[`IRQ_FP_TRAP] | fp_trap;
      nxt_irq_stat[`IRQ_UNUSABLE] = nxt_irq_stat[`IRQ_UNUSABLE] | fp_unusable | fp_reserved;
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_ff <= `CTRL_RESET;
         fctl_ff <= `FCTL_RESET;
         irq_stat_ff <= `IRQ_RESET;
         irq_mask_ff <= `IRQ_RESET;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == `OFS_CTRL)
            ctrl_ff <= reg_wdata_i[1:0];
         fctl_ff <= nxt_fctl;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         rdata_ff <= 32'h0000_0000;
      else
      begin
         rdata_ff <= 32'h0000_0000;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `OFS_CTRL: rdata_ff <= {30'h0, ctrl_ff};
               `OFS_FCTL: rdata_ff <= {14'h0, fctl_ff};
               `OFS_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
               `OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign reg_rdata_o = rdata_ff;
   assign irq_o = irq_ff;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_ovf_detect;
      (op == OP_ADD_TRAP && sum33[32] != sum33[31]) |=> excp_ff.int_ovf;
   endproperty
   a_ovf_detect: assert property (p_ovf_detect) else $error("register add overflow missed"); // RULE_01

   property p_ovf_no_write;
      (op == OP_ADD_TRAP && int_ovf) |=> !retire_ff.int_wr && retire_ff.valid;
   endproperty
   a_ovf_no_write: assert property (p_ovf_no_write) else $error("overflowed add wrote"); // RULE_02

   property p_add_result;
      (op == OP_ADD_TRAP && !int_ovf) |=> retire_ff.int_wr
         && retire_ff.data == {{32{$past(sum33[31])}}, $past(sum33[31:0])};
   endproperty
   a_add_result: assert property (p_add_result) else $error("register add result wrong"); // RULE_03

   property p_decode_shamt;
      (issue_i.valid && opcode == `OP_SPECIAL && funct == `FN_ADD_TRAP && shamt != 5'h00)
         |=> !retire_ff.valid && !excp_ff.int_ovf;
   endproperty
   a_decode_shamt: assert property (p_decode_shamt) else $error("bad add form accepted"); // RULE_04

   property p_imm_trap;
      (op == OP_IMM_TRAP && int_ovf) |=> excp_ff.int_ovf && !retire_ff.int_wr;
   endproperty
   a_imm_trap: assert property (p_imm_trap) else $error("immediate overflow not trapped"); // RULE_05

   property p_imm_wrap;
      (op == OP_IMM_WRAP) |=> !excp_ff.int_ovf && retire_ff.int_wr && retire_ff.dest == $past(srcb_f);
   endproperty
   a_imm_wrap: assert property (p_imm_wrap) else $error("wrapping immediate trapped"); // RULE_07

   property p_wrap_add;
      (op == OP_ADD_WRAP) |=> !excp_ff.int_ovf && retire_ff.data[63:31] == {33{$past(sum33[31])}};
   endproperty
   a_wrap_add: assert property (p_wrap_add) else $error("wrapping add wrong"); // RULE_08

   property p_abs_sign;
      (op == OP_FABS && fp_go && fmt_double && !fp_trap) |=> retire_ff.fp_wr && !retire_ff.data[63];
   endproperty
   a_abs_sign: assert property (p_abs_sign) else $error("absolute kept sign"); // RULE_10

   property p_flags_sticky;
      (fp_go && !fp_trap && !reg_wr_i) |=> (fctl_ff[`FCTL_FLAG_MSB:`FCTL_FLAG_LSB]
         & $past(fp_cause[4:0])) == $past(fp_cause[4:0]);
   endproperty
   a_flags_sticky: assert property (p_flags_sticky) else $error("flags not ORed"); // RULE_12

   sequence s_fp_disabled;
      fp_op && !ctrl_ff[`CTRL_FPU_EN];
   endsequence
   sequence s_unusable_seen;
      excp_ff.unusable && !retire_ff.fp_wr ##0 irq_stat_ff[`IRQ_UNUSABLE];
   endsequence
   property p_unusable;
      s_fp_disabled |=> s_unusable_seen;
   endproperty
   a_unusable: assert property (p_unusable) else $error("disabled unit not refused"); // RULE_16
endmodule : integer_float_add_unit

// ### verification/pipe_model.sv
// pipeline model that issues one decoded instruction at a time
`timescale 1ns/1ps
module pipe_model
   import integer_float_add_unit_pkg::*;
(
   input wire logic clk_i,
   output issue_t issue_o
);
   initial issue_o = '0;
   function automatic logic [63:0] sx(input logic [63:0] v, input logic fp);
      return fp ? v : {{32{v[31]}}, v[31:0]};
   endfunction : sx
   task automatic send(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
      logic fp;
      fp = ins[31:26] == 6'h11;
      @(posedge clk_i);
      issue_o <= {1'b1, ins, sx(a, fp), sx(b, fp)};
      @(posedge clk_i);
      issue_o <= {1'b0, ~ins, ~a, ~b};
   endtask : send
endmodule : pipe_model

// ### verification/testbench.sv
// self-checking bench for the integer and float add unit
`timescale 1ns/1ps
module testbench;
   import integer_float_add_unit_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   issue_t issue_i;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   retire_t retire_o;
   excp_t excp_o;
   logic irq_o;
   int failures = 0;
   int checks = 0;
   logic [31:0] ta [4] = '{32'h7fffffff, 32'h80000000, 32'h7fff8000, 32'hffffffff};
   logic [31:0] tb [4] = '{32'h00000001, 32'hffffffff, 32'h00008000, 32'hffffffff};
   always #50 clk_i = ~clk_i;
   pipe_model pipe_model_inst (.clk_i(clk_i), .issue_o(issue_i));
   integer_float_add_unit integer_float_add_unit_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .issue_i(issue_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .retire_o(retire_o), .excp_o(excp_o), .irq_o(irq_o));
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("reg_rdata_o", 64'(reg_rdata_o), 64'(exp));
   endtask : reg_rd
   // issue one instruction, then compare retire and exception one cycle later
   task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
         input logic [63:0] d, input logic [1:0] wr, input logic ok, input logic [3:0] ex);
      pipe_model_inst.send(ins, a, b);
      #1 chk("retire_valid", 64'(retire_o.valid), 64'(ok));
      chk("excp_o", 64'(excp_o), 64'(ex));
      chk("wr_kind", 64'({retire_o.int_wr, retire_o.fp_wr}), 64'(wr));
      if (wr != 2'b00)
      begin
         chk("dest", 64'(retire_o.dest), ins[31:26] == 6'h08 || ins[31:26] == 6'h09 ?
            64'(ins[20:16]) : ins[31:26] == 6'h11 ? 64'(ins[10:6]) : 64'(ins[15:11]));
         chk("data", retire_o.data, d);
      end
   endtask : run
   function automatic logic [31:0] fi(input logic [4:0] fmt, input logic [5:0] fn,
         input int ft);
      return {6'h11, fmt, 5'(ft), 5'd2, 5'd5, fn};
   endfunction : fi
   initial
   begin
      logic [31:0] a;
      logic [31:0] b;
      logic [32:0] s;
      logic ovf;
      logic [31:0] ins;
      int k;
      void'($urandom(32'h2fb2));
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      reg_rd(8'h00, 32'h0);
      reg_rd(8'h10, 32'h0);
      reg_wr(8'h0c, 32'h1);
      for (int i = 0; i < 24; i++)
      begin
         k = i % 4;
         a = i < 16 ? ta[i / 4] : $urandom;
         b = i < 16 ? tb[i / 4] : $urandom;
         if (k % 2 == 1)
            b = {{16{b[15]}}, b[15:0]};
         s = {a[31], a} + {b[31], b};
         ovf = k < 2 && s[32] != s[31];
         ins = k % 2 == 1 ? {k == 1 ? 6'h08 : 6'h09, 5'd3, 5'd9, b[15:0]} :
            {6'h00, 5'd3, 5'd4, 5'd7, 5'h00, k == 0 ? 6'h20 : 6'h21};
         run(ins, a, b, {{32{s[31]}}, s[31:0]}, {!ovf, 1'b0}, 1'b1, {ovf, 3'b0});
      end
      run({6'h00, 5'd3, 5'd4, 5'd7, 5'h01, 6'h20}, 64'h1, 64'h1, 64'h0, 2'b00, 1'b0,
         4'h0);
      chk("irq_o", 64'(irq_o), 64'h1);
      reg_rd(8'h08, 32'h1);
      chk("irq_o", 64'(irq_o), 64'h0);
      $display("test integer done");
      run(fi(5'h10, 6'h05, 0), 32'hbf800000, 0, 0, 2'b00, 1'b1, 4'h2);
      reg_wr(8'h00, 32'h1);
      run(fi(5'h10, 6'h05, 0), 32'hbf800000, 0, 64'h3f800000, 2'b01, 1'b1, 4'h0);
      run(fi(5'h10, 6'h00, 4), 32'h3f800000, 32'h40000000, 64'h40400000, 2'b01, 1'b1,
         4'h0);
      run(fi(5'h16, 6'h00, 4), 0, 0, 0, 2'b00, 1'b1, 4'h1);
      run(fi(5'h14, 6'h00, 4), 0, 0, 0, 2'b00, 1'b1, 4'h1);
      reg_wr(8'h00, 32'h3);
      run(fi(5'h16, 6'h00, 4), 64'h3f800000_40000000, 64'h40000000_40000000,
         64'h40400000_40800000, 2'b01, 1'b1, 4'h0);
      run(fi(5'h16, 6'h05, 0), 64'hbf800000_c0000000, 0, 64'h3f800000_40000000,
         2'b01, 1'b1, 4'h0);
      run(fi(5'h11, 6'h05, 0), 64'hbff0000000000000, 0, 64'h3ff0000000000000,
         2'b01, 1'b1, 4'h0);
      run(fi(5'h10, 6'h05, 0), 32'hffc00000, 0, 64'h7fc00000, 2'b01, 1'b1, 4'h0);
      reg_rd(8'h04, 32'h0001_0040);
      run(fi(5'h10, 6'h00, 4), 32'h3f800000, 32'h33800000, 64'h3f800000, 2'b01, 1'b1,
         4'h0);
      reg_wr(8'h04, 32'h2);
      run(fi(5'h10, 6'h00, 4), 32'h3f800000, 32'h33800000, 64'h3f800001, 2'b01, 1'b1,
         4'h0);
      reg_rd(8'h04, 32'h0000_1006);
      // inexact enabled: trap, no write, flags left alone
      reg_wr(8'h04, 32'h82);
      run(fi(5'h10, 6'h00, 4), 32'h3f800000, 32'h33800000, 64'h0, 2'b00, 1'b1,
         4'h4);
      reg_rd(8'h04, 32'h0000_1082);
      chk("irq_o", 64'(irq_o), 64'h0);
      reg_rd(8'h08, 32'h6);
      reg_rd(8'h0c, 32'h1);
      $display("test float done");
      give_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      give_verdict();
   end
endmodule : testbench
